/* common/ssr_regs.svh */
// Summary of operation
// (R1) Sixteen words of 64 bits each.
// (R2) Device shifts only on processor sync strobes.
// (R3) Processor clears all sixteen words after reset.
// (R4) Processor holds select low while awaiting ready.
// (R5) Device drops ready when able to communicate.
// (R6) Data input must be low at ready drop.
// (R7) Start bit within 3 to 12 bits.
// (R8) Frame: start, rw, delay, address, data.
// (R9) Data phase shifts word out or in.
// (R10) Ready returns high after frame ends.
// (R11) One select line per device, up to fourteen.
// (R12) Rw one reads; address picks the word.
// (R13) Stored words keep contents between transfers.
//
// Purpose: Constants shared by both ends of the serial word store link.
// Assumes: A 250 MHz system clock on both ends.
// Notes:   Frame bit indices count from the start bit at index 0.
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH

// ----------------------------------------------------------------------------
// Storage geometry
// ----------------------------------------------------------------------------
`define SSR_WORDS          16
`define SSR_WORD_BITS      64
`define SSR_ADDR_BITS      4
`define SSR_FIFO_DEPTH     16

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SSR_CLK_PERIOD_NS  4
`define SSR_BIT_TIME_NS    10000
`define SSR_BIT_CYCLES     ((`SSR_BIT_TIME_NS + `SSR_CLK_PERIOD_NS - 1) / `SSR_CLK_PERIOD_NS)
`define SSR_SYNC_PHASE     (`SSR_BIT_CYCLES / 2)
`define SSR_START_MIN      3
`define SSR_START_MAX      12
`define SSR_LEAD_BITS      3

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define SSR_IDX_RW         1
`define SSR_IDX_DELAY0     2
`define SSR_IDX_ADDR0      6
`define SSR_IDX_DATA0      10
`define SSR_IDX_LAST       73
`define SSR_FRAME_BITS     75
`define SSR_RW_READ        1'b1

`endif

/* common/ssr_pkg.sv */
// Purpose: Types for both ends of the serial word store link.
// Assumes: Nothing beyond the shared constants header.
// Notes:   State codes are written out in binary.
package ssr_pkg;

    // ------------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        D_IDLE  = 2'b00,
        D_WAIT  = 2'b01,
        D_FRAME = 2'b10,
        D_GAP   = 2'b11
    } dev_state_e;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_WAIT = 3'b001,
        H_LEAD = 3'b010,
        H_SEND = 3'b011,
        H_END  = 3'b100
    } host_state_e;

    typedef logic [63:0] word_t;

endpackage : ssr_pkg

/* common/ssr_link_if.sv */
// Purpose: Serial link between the processor end and the word store end.
// Assumes: Both ends run on the same clock.
// Notes:   All signals are plain levels; sync is a one-cycle strobe.
`timescale 1ns/1ps
interface ssr_link_if;
    logic sel_n;          // Unit select, active low, from the processor.
    logic sync;           // Bit strobe, one cycle per bit time.
    logic din;            // Serial data into the store.
    logic dout;           // Serial data out of the store.
    logic ready_flag_out; // Ready, low while the store communicates.

    modport dev  (input sel_n, input sync, input din, output dout, output ready_flag_out);
    modport host (output sel_n, output sync, output din, input dout, input ready_flag_out);
endinterface : ssr_link_if

/* hw/ssr_device.sv */
// Purpose: Word store end: sixteen recirculating 64-bit words on a serial link.
// Assumes: Link signals are synchronous to clk; sync marks the sample point.
// Notes:   Contents have no reset; the processor clears them after power on.
`timescale 1ns/1ps
`include "ssr_regs.svh"
module ssr_device (
    input  wire logic clk,   // System clock.
    input  wire logic rstn,  // Asynchronous reset, active low.
    ssr_link_if.dev   link,  // Serial link to the processor.
    output logic      busy   // High while a handshake is in progress.
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    ssr_pkg::dev_state_e state;
    ssr_pkg::dev_state_e next_state;
    logic                ready;
    logic                next_ready;
    logic [3:0]          cnt;
    logic [3:0]          next_cnt;
    logic [6:0]          idx;
    logic [6:0]          next_idx;
    logic                rw;
    logic                next_rw;
    logic [3:0]          addr;
    logic [3:0]          next_addr;
    logic                dout;
    logic                next_dout;
    logic                shift_en;
    ssr_pkg::word_t      next_word;
    ssr_pkg::word_t      cur_word;
    logic [3:0]          bits_seen;

    // (R1) sixteen word store
    ssr_pkg::word_t mem [`SSR_WORDS];

    assign cur_word  = mem[addr];
    assign bits_seen = cnt + 4'h1;

    // Handshake sequencing, evaluated only on sync strobes.
    always_comb begin
        next_state = state;
        next_ready = ready;
        next_cnt   = cnt;
        next_idx   = idx;
        next_rw    = rw;
        next_addr  = addr;
        next_dout  = dout;
        shift_en   = 1'b0;
        next_word  = cur_word;
        // (R2) act on sync only
        if (link.sync) begin
            unique case (state)
                ssr_pkg::D_IDLE: begin
                    // (R5) drop ready when selected
                    // (R6) require data input low
                    if (!link.sel_n && !link.din) begin
                        next_ready = 1'b0;
                        next_cnt   = 4'h0;
                        next_state = ssr_pkg::D_WAIT;
                    end
                end
                ssr_pkg::D_WAIT: begin
                    next_cnt = bits_seen;
                    if (link.sel_n) begin
                        next_ready = 1'b1;
                        next_state = ssr_pkg::D_IDLE;
                    // (R7) start window check
                    end else if (link.din) begin
                        if (bits_seen >= 4'(`SSR_START_MIN) && bits_seen <= 4'(`SSR_START_MAX)) begin
                            next_idx   = 7'h1;
                            next_state = ssr_pkg::D_FRAME;
                        end else begin
                            next_ready = 1'b1;
                            next_state = ssr_pkg::D_GAP;
                        end
                    end else if (bits_seen == 4'(`SSR_START_MAX)) begin
                        next_ready = 1'b1;
                        next_state = ssr_pkg::D_GAP;
                    end
                end
                ssr_pkg::D_FRAME: begin
                    next_idx = idx + 7'h1;
                    if (link.sel_n) begin
                        next_ready = 1'b1;
                        next_dout  = 1'b0;
                        next_state = ssr_pkg::D_IDLE;
                    end else begin
                        // (R8) frame field order
                        if (idx == 7'(`SSR_IDX_RW)) begin
                            // (R12) rw and address
                            next_rw = link.din;
                        end else if (idx >= 7'(`SSR_IDX_ADDR0) && idx < 7'(`SSR_IDX_DATA0)) begin
                            next_addr = {addr[2:0], link.din};
                        end else if (idx >= 7'(`SSR_IDX_DATA0)) begin
                            // (R9) shift word in or out
                            // (R13) read recirculates word
                            shift_en  = 1'b1;
                            next_word = {(rw == `SSR_RW_READ) ? cur_word[0] : link.din, cur_word[63:1]};
                            next_dout = (rw == `SSR_RW_READ) ? cur_word[0] : 1'b0;
                        end
                        // (R10) ready high at frame end
                        if (idx == 7'(`SSR_IDX_LAST)) begin
                            next_ready = 1'b1;
                            next_state = ssr_pkg::D_GAP;
                        end
                    end
                end
                ssr_pkg::D_GAP: begin
                    next_dout  = 1'b0;
                    next_state = ssr_pkg::D_IDLE;
                end
            endcase
        end
    end

    // Control registers.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ssr_pkg::D_IDLE;
            ready <= 1'b1;
            cnt   <= 4'h0;
            idx   <= 7'h0;
            rw    <= 1'b0;
            addr  <= 4'h0;
            dout  <= 1'b0;
        end else begin
            state <= next_state;
            ready <= next_ready;
            cnt   <= next_cnt;
            idx   <= next_idx;
            rw    <= next_rw;
            addr  <= next_addr;
            dout  <= next_dout;
        end
    end

    // (R13) unaddressed words hold
    always_ff @(posedge clk) begin
        if (shift_en) begin
            mem[addr] <= next_word;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign link.ready_flag_out = ready;
    assign link.dout           = dout;
    assign busy                = (state != ssr_pkg::D_IDLE);

endmodule : ssr_device

/* hw/ssr_host.sv */
// Purpose: Processor end: runs transfers to the word store from a request port.
// Assumes: One store on the link; select for others is decoded outside.
// Notes:   Read words pass through a FIFO; a full FIFO holds off reads.
`timescale 1ns/1ps
`include "ssr_regs.svh"
module ssr_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,       // System clock.
    input  wire logic             rstn,      // Asynchronous reset, active low.
    input  wire logic             in_valid,  // Write side valid.
    output logic                  in_ready,  // Write side ready.
    input  wire logic [WIDTH-1:0] in_data,   // Write side data.
    output logic                  out_valid, // Read side valid.
    input  wire logic             out_ready, // Read side ready.
    output logic [WIDTH-1:0]      out_data   // Read side data.
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] buf_mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    // Full when pointers differ only in the wrap bit.
    assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data  = buf_mem[rd_ptr[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer advance.
    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    // Pointer registers.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage write.
    always_ff @(posedge clk) begin
        if (push) begin
            buf_mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule : ssr_fifo

module ssr_host (
    input  wire logic        clk,       // System clock.
    input  wire logic        rstn,      // Asynchronous reset, active low.
    ssr_link_if.host         link,      // Serial link to the store.
    input  wire logic        req_valid, // Transfer request valid.
    output logic             req_ready, // Request taken this cycle.
    input  wire logic        req_rw,    // One for read, zero for write.
    input  wire logic [3:0]  req_addr,  // Word address.
    input  wire logic [63:0] req_wdata, // Write data.
    output logic             rd_valid,  // Read word available.
    input  wire logic        rd_ready,  // Read word consumed.
    output logic [63:0]      rd_data,   // Read word.
    output logic             init_done, // Power-on clear finished.
    output logic             busy       // Transfer in progress.
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    ssr_pkg::host_state_e          state;
    ssr_pkg::host_state_e          next_state;
    logic [11:0]                   tick;
    logic [11:0]                   next_tick;
    logic [`SSR_FRAME_BITS-1:0]    frame;
    logic [`SSR_FRAME_BITS-1:0]    next_frame;
    logic [6:0]                    idx;
    logic [6:0]                    next_idx;
    logic [3:0]                    wc;
    logic [3:0]                    next_wc;
    logic                          rw;
    logic                          next_rw;
    logic                          sel_n;
    logic                          next_sel_n;
    logic                          din;
    logic                          next_din;
    ssr_pkg::word_t                rdata;
    ssr_pkg::word_t                next_rdata;
    logic                          push;
    logic                          next_push;
    logic [4:0]                    init_cnt;
    logic [4:0]                    next_init_cnt;
    logic                          fifo_in_ready;
    logic                          boundary;
    logic                          take;
    logic                          go_rw;
    logic [3:0]                    go_addr;
    ssr_pkg::word_t                go_data;

    assign boundary  = (tick == 12'h000);
    // (R3) clear all words first
    assign init_done = (init_cnt == 5'(`SSR_WORDS));
    assign take      = boundary && (state == ssr_pkg::H_IDLE) && init_done && req_valid
                       && (!req_rw || fifo_in_ready);
    assign req_ready = take;
    assign go_rw     = init_done ? req_rw : 1'b0;
    assign go_addr   = init_done ? req_addr : init_cnt[3:0];
    assign go_data   = init_done ? req_wdata : 64'h0000000000000000;

    // Bit timer, frame sequencing and data capture.
    always_comb begin
        next_tick     = (tick == 12'(`SSR_BIT_CYCLES - 1)) ? 12'h000 : tick + 12'h001;
        next_state    = state;
        next_frame    = frame;
        next_idx      = idx;
        next_wc       = wc;
        next_rw       = rw;
        next_sel_n    = sel_n;
        next_din      = din;
        next_rdata    = rdata;
        next_push     = 1'b0;
        next_init_cnt = init_cnt;
        if (boundary) begin
            unique case (state)
                ssr_pkg::H_IDLE: begin
                    if (take || !init_done) begin
                        // (R8) build start, rw, delay, address, data
                        // (R12) rw and address encoding
                        next_frame = {1'b0, go_data, go_addr[0], go_addr[1], go_addr[2], go_addr[3],
                                      4'h0, go_rw, 1'b1};
                        next_rw    = go_rw;
                        // (R4) select low, data low
                        // (R11) single select line
                        next_sel_n = 1'b0;
                        next_din   = 1'b0;
                        next_state = ssr_pkg::H_WAIT;
                    end
                end
                ssr_pkg::H_WAIT: begin
                    if (!link.ready_flag_out) begin
                        next_wc    = 4'h1;
                        next_state = ssr_pkg::H_LEAD;
                    end
                end
                ssr_pkg::H_LEAD: begin
                    if (link.ready_flag_out) begin
                        next_state = ssr_pkg::H_WAIT;
                    // (R7) start after lead bits
                    end else if (wc == 4'(`SSR_LEAD_BITS)) begin
                        next_din   = frame[0];
                        next_frame = frame >> 1;
                        next_idx   = 7'h1;
                        next_state = ssr_pkg::H_SEND;
                    end else begin
                        next_wc = wc + 4'h1;
                    end
                end
                ssr_pkg::H_SEND: begin
                    next_din   = frame[0];
                    next_frame = frame >> 1;
                    next_idx   = idx + 7'h1;
                    if (rw && idx > 7'(`SSR_IDX_DATA0)) begin
                        next_rdata = {link.dout, rdata[63:1]};
                    end
                    if (idx == 7'(`SSR_FRAME_BITS - 1)) begin
                        next_state = ssr_pkg::H_END;
                    end
                end
                ssr_pkg::H_END: begin
                    next_sel_n = 1'b1;
                    next_push  = rw;
                    if (!init_done) begin
                        next_init_cnt = init_cnt + 5'h01;
                    end
                    next_state = ssr_pkg::H_IDLE;
                end
                default: begin
                    next_state = ssr_pkg::H_IDLE;
                end
            endcase
        end
    end

    // Registers.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state    <= ssr_pkg::H_IDLE;
            tick     <= 12'h000;
            frame    <= '0;
            idx      <= 7'h0;
            wc       <= 4'h0;
            rw       <= 1'b0;
            sel_n    <= 1'b1;
            din      <= 1'b0;
            rdata    <= 64'h0000000000000000;
            push     <= 1'b0;
            init_cnt <= 5'h00;
        end else begin
            state    <= next_state;
            tick     <= next_tick;
            frame    <= next_frame;
            idx      <= next_idx;
            wc       <= next_wc;
            rw       <= next_rw;
            sel_n    <= next_sel_n;
            din      <= next_din;
            rdata    <= next_rdata;
            push     <= next_push;
            init_cnt <= next_init_cnt;
        end
    end

    // Read word buffer.
    ssr_fifo #(
        .WIDTH (64),
        .DEPTH (`SSR_FIFO_DEPTH)
    ) ssr_fifo_i (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (rdata),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign link.sel_n = sel_n;
    assign link.din   = din;
    assign link.sync  = (tick == 12'(`SSR_SYNC_PHASE));
    assign busy       = (state != ssr_pkg::H_IDLE) || !init_done;

endmodule : ssr_host

/* testbench/serial_shift_register_memory_assertions.sv */
// Purpose: Link checks between the processor end and the word store end.
// Assumes: One clock; the store moves ready and dout only on strobe cycles.
// Notes:   Counters measure spans in clock cycles.
`timescale 1ns/1ps
`include "ssr_regs.svh"
module serial_shift_register_memory_assertions (
    input wire logic clk,           // System clock.
    input wire logic rstn,          // Reset, active low.
    input wire logic sel_n,         // Unit select.
    input wire logic sync,          // Bit strobe.
    input wire logic din,           // Data into the store.
    input wire logic dout,          // Data out of the store.
    input wire logic ready_flag_out // Ready, low within a frame.
);
    localparam int BIT   = `SSR_BIT_CYCLES;
    localparam int FRAME = (`SSR_IDX_LAST + 4) * BIT;
    logic [31:0] gap, low_cnt, high_cnt, next_gap, next_low_cnt, next_high_cnt;
    logic        seen, started, next_seen, next_started;

    // --------
    // Span counters
    // --------
    // Next values: cycles since strobe, since ready fell or rose, first start.
    always_comb begin
        next_gap      = sync ? 32'h0 : gap + 32'h1;
        next_seen     = seen | sync;
        next_low_cnt  = ready_flag_out ? 32'h0 : low_cnt + 32'h1;
        next_high_cnt = ready_flag_out ? high_cnt + 32'h1 : 32'h0;
        next_started  = !ready_flag_out & (started | din);
    end

    // High span starts long, so the first handshake after reset is not a gap.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap      <= 32'h0;
            seen     <= 1'b0;
            low_cnt  <= 32'h0;
            high_cnt <= 32'h0010_0000;
            started  <= 1'b0;
        end else begin
            gap      <= next_gap;
            seen     <= next_seen;
            low_cnt  <= next_low_cnt;
            high_cnt <= next_high_cnt;
            started  <= next_started;
        end
    end

    // --------
    // Properties
    // --------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_hs_open;
        $fell(ready_flag_out);
    endsequence
    sequence s_hs_close;
        $rose(ready_flag_out);
    endsequence

    a_sync_spacing: assert property (sync && seen |-> gap == 32'(BIT - 1))
        else $error("strobes not one bit time apart");
    a_ready_fall_cause: assert property (s_hs_open |-> $past(sync) && !$past(sel_n) && !$past(din))
        else $error("ready fell without select and low data on a strobe");
    a_ready_rise_sync: assert property (s_hs_close |-> $past(sync))
        else $error("ready rose off a strobe");
    a_frame_span: assert property (s_hs_close |-> low_cnt == 32'(FRAME))
        else $error("frame length wrong");
    a_start_window: assert property ($rose(din) && !ready_flag_out && !started
        |-> low_cnt >= 32'(`SSR_START_MIN * BIT) && low_cnt <= 32'(`SSR_START_MAX * BIT))
        else $error("start bit outside its window");
    a_gap_bit: assert property (s_hs_open |-> high_cnt >= 32'(2 * BIT))
        else $error("ready fell again without a gap bit");
    a_dout_on_sync: assert property ($changed(dout) |-> $past(sync))
        else $error("dout moved off a strobe");
    a_din_off_sync: assert property ($changed(din) |-> !$past(sync))
        else $error("din moved on a strobe");
    a_select_held: assert property ($rose(sel_n) |-> ready_flag_out)
        else $error("select released while ready low");
endmodule : serial_shift_register_memory_assertions

/* testbench/serial_shift_register_memory_bench.sv */
// Purpose: Runs both link ends together, and one store against a faulty driver.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Frames last about 80 bit times, so the run spans millions of cycles.
`timescale 1ns/1ps
`include "ssr_regs.svh"
module serial_shift_register_memory_bench;
    localparam int          BIT = `SSR_BIT_CYCLES;
    localparam logic [63:0] W0  = 64'h0123_4567_89ab_cdef;
    localparam logic [63:0] WF  = 64'h8000_0000_0000_0001;
    logic        clk, rstn, req_valid, req_ready, req_rw, rd_valid, rd_ready, init_done, busy, dbusy;
    logic [3:0]  req_addr;
    logic [63:0] req_wdata, rd_data;
    logic [76:0] fr = 77'h0;
    int          fails = 0, compares = 0, c2 = 0, n;
    ssr_link_if link ();
    ssr_link_if link2 ();
    ssr_device ssr_device_i (.clk(clk), .rstn(rstn), .link(link), .busy());
    ssr_device ssr_device_i2 (.clk(clk), .rstn(rstn), .link(link2), .busy(dbusy));
    ssr_host ssr_host_i (.clk(clk), .rstn(rstn), .link(link), .req_valid(req_valid), .req_ready(req_ready),
        .req_rw(req_rw), .req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data), .init_done(init_done), .busy(busy));
    serial_shift_register_memory_assertions serial_shift_register_memory_assertions_i (.clk(clk), .rstn(rstn),
        .sel_n(link.sel_n), .sync(link.sync), .din(link.din), .dout(link.dout),
        .ready_flag_out(link.ready_flag_out));

    // --------
    // Clocks and monitors
    // --------
    // Clock of 4 ns.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Strobe for the store facing the faulty driver.
    always @(negedge clk) c2 <= (c2 == BIT - 1) ? 0 : c2 + 1;
    assign link2.sync = (c2 == BIT / 2);
    // Shifts din in at each strobe within a frame; the oldest bit lands at index 0.
    always @(posedge clk) if (link.sync === 1'b1 && link.ready_flag_out === 1'b0) fr <= {link.din, fr[76:1]};

    task check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            fails++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : check

    task conclude;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // Presents one request and holds it until taken.
    task xfer(input logic rw, input logic [3:0] a, input logic [63:0] d);
        @(negedge clk);
        {req_valid, req_rw, req_addr, req_wdata} = {1'b1, rw, a, d};
        n = 0;
        while (req_ready !== 1'b1 && n < 100 * BIT) begin @(negedge clk); n++; end
        check(req_ready === 1'b1, "request not taken");
        @(negedge clk);
        req_valid = 1'b0;
    endtask : xfer

    // Writes a word, then compares the bits seen on din with the frame layout.
    task wr_check(input logic [3:0] a, input logic [63:0] d);
        logic [76:0] e;
        xfer(1'b0, a, d);
        n = 0;
        while (busy !== 1'b0 && n < 100 * BIT) begin @(negedge clk); n++; end
        e = {d, 13'h0008};
        for (int i = 0; i < 4; i++) e[9 + i] = a[3 - i];
        check(fr === e, "write frame bits on the wire");
    endtask : wr_check

    // Selects the second store, then sends start too early or never.
    task fault(input logic early);
        link2.sel_n = 1'b0;
        n = 0;
        while (link2.ready_flag_out !== 1'b0 && n < 3 * BIT) begin @(negedge clk); n++; end
        check(link2.ready_flag_out === 1'b0 && dbusy === 1'b1, "ready did not drop");
        if (early) begin
            repeat (BIT) @(negedge clk);
            link2.din = 1'b1;
        end
        n = 0;
        while (link2.ready_flag_out !== 1'b1 && n < 15 * BIT) begin @(negedge clk); n++; end
        check(early ? n < 2 * BIT : n > 11 * BIT && n < 14 * BIT, "refusal timing wrong");
        link2.sel_n = 1'b1;
        link2.din = 1'b0;
        repeat (3 * BIT) @(negedge clk);
        check(dbusy === 1'b0 && link2.ready_flag_out === 1'b1, "store not idle");
    endtask : fault

    // --------
    // Stimulus
    // --------
    // Reset, faulty handshakes, clear, writes, reads until the buffer refuses, drain.
    initial begin
        {rstn, req_valid, req_rw, rd_ready, req_addr, req_wdata} = 72'h0;
        {link2.sel_n, link2.din} = 2'b10;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        fault(1'b1);
        fault(1'b0);
        n = 0;
        while (init_done !== 1'b1 && n < 1600 * BIT) begin @(negedge clk); n++; end
        check(init_done === 1'b1, "clear not done");
        wr_check(4'h0, W0);
        wr_check(4'hf, WF);
        for (int a = 0; a < 16; a++) xfer(1'b1, a[3:0], 64'h0);
        n = 0;
        while (busy !== 1'b0 && n < 100 * BIT) begin @(negedge clk); n++; end
        @(negedge clk);
        {req_valid, req_rw} = 2'b11;
        n = 0;
        repeat (4 * BIT) begin @(negedge clk); if (req_ready !== 1'b0) n++; end
        check(n == 0, "read taken while buffer full");
        req_valid = 1'b0;
        @(negedge clk);
        rd_ready = 1'b1;
        for (int a = 0; a < 16; a++) begin
            check(rd_valid === 1'b1 && rd_data === (a == 0 ? W0 : a == 15 ? WF : 64'h0), "read word");
            @(negedge clk);
        end
        rd_ready = 1'b0;
        check(rd_valid === 1'b0, "buffer not empty");
        xfer(1'b1, 4'h0, 64'h0);
        n = 0;
        while (rd_valid !== 1'b1 && n < 100 * BIT) begin @(negedge clk); n++; end
        check(rd_data === W0, "word lost after read");
        conclude();
    end

    // Cuts a hang short after about 4000 bit times.
    initial begin
        repeat (4000 * BIT) @(posedge clk);
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
endmodule : serial_shift_register_memory_bench
